// file: verilog/ppol_top.sv
// Port B override logic, port C and port D with register access
//
// Summary of operation
// (RULE1) SPI master forces MISO pin to input
// (RULE2) SPI slave: MISO direction from bit 6
// (RULE3) MOSI input as slave, bit 5 as master
// (RULE4) SS input as slave, bit 4 as master
// (RULE5) Slave SPI active only while SS low
// (RULE6) Forced inputs keep latch-controlled pull-up
// (RULE7) Power-down gates comparator pin digital readback
// (RULE8) Port B bits 1, 0 feed timer counters
// (RULE9) All pin inputs are synchronized first
// (RULE10) Port C: eight independent bidirectional pins
// (RULE11) Latch address reads latch, pin address pins
// (RULE12) Direction one drives latch, zero is input
// (RULE13) Pull-up only for input with latch one
// (RULE14) Reset tristates pins without needing clock
// (RULE15) Async timer 2 detaches port C pins 6, 7
// (RULE16) Port D: latch, direction, read-only pin address
// (RULE17) Port D pins carry UART, irq, timer functions
// (RULE18) SCK input as slave, bit 7 as master
// (RULE19) UART transmitter forces port D bit 1 output
// (RULE20) UART receiver forces port D bit 0 input
// (RULE21) Pin synchronizer is two flops deep
//
// Added by the designer: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module ppol_top #(
    parameter int unsigned PORT_W = 8
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    // Register port
    input  wire logic [5:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_we,
    input  wire logic        reg_re,
    output logic      [7:0]  reg_rdata,
    // Port B pins
    input  wire logic [7:0]  pb_in,
    output logic      [7:0]  pb_out,
    output logic      [7:0]  pb_oe_n,
    output logic      [7:0]  pb_pullup_en,
    // Port C pins
    input  wire logic [7:0]  pc_in,
    output logic      [7:0]  pc_out,
    output logic      [7:0]  pc_oe_n,
    output logic      [7:0]  pc_pullup_en,
    // Port D pins
    input  wire logic [7:0]  pd_in,
    output logic      [7:0]  pd_out,
    output logic      [7:0]  pd_oe_n,
    output logic      [7:0]  pd_pullup_en,
    // SPI controls and data from the SPI
    input  wire logic        spi_enable,
    input  wire logic        spi_master,
    input  wire logic        spi_sck_out,
    input  wire logic        spi_mosi_out,
    input  wire logic        spi_miso_out,
    // SPI data towards the SPI
    output logic             spi_sck_in,
    output logic             spi_mosi_in,
    output logic             spi_miso_in,
    output logic             spi_slave_active,
    // Power and timer controls
    input  wire logic        power_down,
    input  wire logic        async_timer2_clock_sel,
    // Counter sources and comparator digital readback
    output logic             timer0_count_in,
    output logic             timer1_count_in,
    output logic             comparator_pos_in,
    output logic             comparator_neg_in,
    // UART
    input  wire logic        uart_tx_enable,
    input  wire logic        uart_rx_enable,
    input  wire logic        uart_txd,
    output logic             uart_rxd,
    // External interrupt and capture inputs
    output logic             ext_irq0_in,
    output logic             ext_irq1_in,
    output logic             t1_capture_in,
    // Timer compare outputs and their enables
    input  wire logic        t1_compare_a_out,
    input  wire logic        t1_compare_a_en,
    input  wire logic        t1_compare_b_out,
    input  wire logic        t1_compare_b_en,
    input  wire logic        t2_compare_out,
    input  wire logic        t2_compare_en
);
    // Registered and next state
    ppol_pkg::ppol_state_t state_q;
    ppol_pkg::ppol_state_t state_d;

    // Synchronized pin levels, all three ports
    logic [3*PORT_W-1:0] pins_sync;
    logic [PORT_W-1:0]   pb_sync;    // Port B after sync
    logic [PORT_W-1:0]   pc_sync;    // Port C after sync
    logic [PORT_W-1:0]   pd_sync;    // Port D after sync

    // Readback views after gating
    logic [PORT_W-1:0]   pb_levels;  // Port B pin readback
    logic [PORT_W-1:0]   pc_levels;  // Port C pin readback
    logic [PORT_W-1:0]   pd_levels;  // Port D pin readback

    // Effective direction and output value per port
    logic [PORT_W-1:0]   pb_dir_eff;
    logic [PORT_W-1:0]   pb_val;
    logic [PORT_W-1:0]   pc_detach;  // Port C pins taken by oscillator
    logic [PORT_W-1:0]   pd_dir_eff;
    logic [PORT_W-1:0]   pd_val;

    // SPI mode decode
    logic                spi_is_master;
    logic                spi_is_slave;

    // Direction bits used by the overrides
    logic                pb_dir_bit4;
    logic                pb_dir_bit5;
    logic                pb_dir_bit6;
    logic                pb_dir_bit7;
    logic                pd_dir_bit1;

    // Read mux result
    logic [7:0]          rd_mux;

    // Pins pass two flops before anything reads them (see RULE9) (see RULE21)
    ppol_sync #(
        .WIDTH    (3 * PORT_W)
    ) u_sync (
        .clk      (clk),
        .rst_n    (rst_n),
        .async_in ({pd_in, pc_in, pb_in}),
        .sync_out (pins_sync)
    );

    // Split the synchronized vector per port
    assign pb_sync = pins_sync[PORT_W-1:0];
    assign pc_sync = pins_sync[2*PORT_W-1:PORT_W];
    assign pd_sync = pins_sync[3*PORT_W-1:2*PORT_W];

    // SPI mode flags
    assign spi_is_master = spi_enable & spi_master;
    assign spi_is_slave  = spi_enable & ~spi_master;

    // Direction bits named for the SPI pins and TXD
    assign pb_dir_bit4 = state_q.pb_dir[ppol_pkg::PB_SS_BIT];
    assign pb_dir_bit5 = state_q.pb_dir[ppol_pkg::PB_MOSI_BIT];
    assign pb_dir_bit6 = state_q.pb_dir[ppol_pkg::PB_MISO_BIT];
    assign pb_dir_bit7 = state_q.pb_dir[ppol_pkg::PB_SCK_BIT];
    assign pd_dir_bit1 = state_q.pd_dir[ppol_pkg::PD_TXD_BIT];

    // Port B direction with SPI overrides
    always_comb begin
        // Plain pins follow their direction bits
        pb_dir_eff = state_q.pb_dir;
        // SCK: input as slave, software direction otherwise
        pb_dir_eff[ppol_pkg::PB_SCK_BIT] = pb_dir_bit7 & ~spi_is_slave;    // see RULE18
        // MISO: input as master, software direction as slave
        pb_dir_eff[ppol_pkg::PB_MISO_BIT] = pb_dir_bit6 & ~spi_is_master;  // see RULE1 see RULE2
        // MOSI: input as slave, software direction as master
        pb_dir_eff[ppol_pkg::PB_MOSI_BIT] = pb_dir_bit5 & ~spi_is_slave;   // see RULE3
        // SS: input as slave, software direction as master
        pb_dir_eff[ppol_pkg::PB_SS_BIT] = pb_dir_bit4 & ~spi_is_slave;     // see RULE4
    end

    // Port B output values with SPI data
    always_comb begin
        // Default drive is the latch
        pb_val = state_q.pb_latch;
        // Master drives clock and data out
        if (spi_is_master) begin
            pb_val[ppol_pkg::PB_SCK_BIT]  = spi_sck_out;
            pb_val[ppol_pkg::PB_MOSI_BIT] = spi_mosi_out;
        end
        // Slave drives its data out
        if (spi_is_slave) begin
            pb_val[ppol_pkg::PB_MISO_BIT] = spi_miso_out;
        end
    end

    // Port C oscillator pins detach
    always_comb begin
        pc_detach = '0;
        pc_detach[ppol_pkg::PC_OSC1_BIT] = async_timer2_clock_sel;  // see RULE15
        pc_detach[ppol_pkg::PC_OSC2_BIT] = async_timer2_clock_sel;  // see RULE15
    end

    // Port D direction with UART overrides
    always_comb begin
        pd_dir_eff = state_q.pd_dir;
        // Transmitter forces TXD to output
        pd_dir_eff[ppol_pkg::PD_TXD_BIT] = pd_dir_bit1 | uart_tx_enable;  // see RULE19
        // Receiver forces RXD to input
        if (uart_rx_enable) begin
            pd_dir_eff[ppol_pkg::PD_RXD_BIT] = 1'b0;  // see RULE20
        end
    end

    // Port D output values
    always_comb begin
        pd_val = state_q.pd_latch;
        // Transmit data on bit 1
        if (uart_tx_enable) begin
            pd_val[ppol_pkg::PD_TXD_BIT] = uart_txd;  // see RULE17
        end
        // Enabled compare outputs replace latch
        if (t1_compare_b_en) begin
            pd_val[ppol_pkg::PD_CMP1B_BIT] = t1_compare_b_out;  // see RULE17
        end
        if (t1_compare_a_en) begin
            pd_val[ppol_pkg::PD_CMP1A_BIT] = t1_compare_a_out;  // see RULE17
        end
        if (t2_compare_en) begin
            pd_val[ppol_pkg::PD_CMP2_BIT] = t2_compare_out;  // see RULE17
        end
    end

    // Port B pads; nothing detached
    ppol_pad #(
        .WIDTH      (PORT_W)
    ) u_pad_b (
        .rst_n      (rst_n),
        .dir_eff    (pb_dir_eff),
        .out_val    (pb_val),
        .latch      (state_q.pb_latch),
        .detach     ({PORT_W{1'b0}}),
        .pin_out    (pb_out),
        .pin_oe_n   (pb_oe_n),
        .pin_pullup (pb_pullup_en)
    );

    // Port C pads; plain latch drive per pin (see RULE10) (see RULE12)
    ppol_pad #(
        .WIDTH      (PORT_W)
    ) u_pad_c (
        .rst_n      (rst_n),
        .dir_eff    (state_q.pc_dir),
        .out_val    (state_q.pc_latch),
        .latch      (state_q.pc_latch),
        .detach     (pc_detach),
        .pin_out    (pc_out),
        .pin_oe_n   (pc_oe_n),
        .pin_pullup (pc_pullup_en)
    );

    // Port D pads
    ppol_pad #(
        .WIDTH      (PORT_W)
    ) u_pad_d (
        .rst_n      (rst_n),
        .dir_eff    (pd_dir_eff),
        .out_val    (pd_val),
        .latch      (state_q.pd_latch),
        .detach     ({PORT_W{1'b0}}),
        .pin_out    (pd_out),
        .pin_oe_n   (pd_oe_n),
        .pin_pullup (pd_pullup_en)
    );

    // Port B readback, comparator pins gated
    always_comb begin
        pb_levels = pb_sync;
        if (power_down) begin
            pb_levels[ppol_pkg::PB_AIN_POS_BIT] = 1'b0;  // see RULE7
            pb_levels[ppol_pkg::PB_AIN_NEG_BIT] = 1'b0;  // see RULE7
        end
    end

    // Port C readback; detached pins read zero
    assign pc_levels = pc_sync & ~pc_detach;  // see RULE15
    // Port D readback is the plain synchronized level
    assign pd_levels = pd_sync;

    // Alternate inputs towards peripherals
    assign timer0_count_in   = pb_sync[ppol_pkg::PB_CNT0_BIT];        // see RULE8
    assign timer1_count_in   = pb_sync[ppol_pkg::PB_CNT1_BIT];        // see RULE8
    assign comparator_pos_in = pb_levels[ppol_pkg::PB_AIN_POS_BIT];
    assign comparator_neg_in = pb_levels[ppol_pkg::PB_AIN_NEG_BIT];
    assign spi_sck_in        = pb_sync[ppol_pkg::PB_SCK_BIT];
    assign spi_mosi_in       = pb_sync[ppol_pkg::PB_MOSI_BIT];
    assign spi_miso_in       = pb_sync[ppol_pkg::PB_MISO_BIT];
    // Slave is selected only while SS is held low
    assign spi_slave_active  = spi_is_slave & ~pb_sync[ppol_pkg::PB_SS_BIT];  // see RULE5
    // UART, interrupt and capture inputs on port D
    assign uart_rxd          = pd_sync[ppol_pkg::PD_RXD_BIT];         // see RULE17
    assign ext_irq0_in       = pd_sync[ppol_pkg::PD_IRQ0_BIT];        // see RULE17
    assign ext_irq1_in       = pd_sync[ppol_pkg::PD_IRQ1_BIT];        // see RULE17
    assign t1_capture_in     = pd_sync[ppol_pkg::PD_CAPT_BIT];        // see RULE17

    // Read mux over all nine addresses
    always_comb begin
        unique case (reg_addr)
            ppol_pkg::PORT_B_OUTPUT_LATCH_OFS: rd_mux = state_q.pb_latch;
            ppol_pkg::PORT_B_DIRECTION_OFS:    rd_mux = state_q.pb_dir;
            ppol_pkg::PORT_B_PIN_LEVELS_OFS:   rd_mux = pb_levels;
            ppol_pkg::PORT_C_OUTPUT_LATCH_OFS: rd_mux = state_q.pc_latch;  // see RULE11
            ppol_pkg::PORT_C_DIRECTION_OFS:    rd_mux = state_q.pc_dir;
            ppol_pkg::PORT_C_PIN_LEVELS_OFS:   rd_mux = pc_levels;         // see RULE11
            ppol_pkg::PORT_D_OUTPUT_LATCH_OFS: rd_mux = state_q.pd_latch;  // see RULE16
            ppol_pkg::PORT_D_DIRECTION_OFS:    rd_mux = state_q.pd_dir;    // see RULE16
            ppol_pkg::PORT_D_PIN_LEVELS_OFS:   rd_mux = pd_levels;         // see RULE16
            default:                           rd_mux = ppol_pkg::READ_IDLE;
        endcase
    end

    // Next state: register writes and read capture
    always_comb begin
        state_d = state_q;
        // Read data stand one cycle
        state_d.rd_data = reg_re ? rd_mux : ppol_pkg::READ_IDLE;
        // Writes land on latch and direction
        if (reg_we) begin
            unique case (reg_addr)
                ppol_pkg::PORT_B_OUTPUT_LATCH_OFS: state_d.pb_latch = reg_wdata;
                ppol_pkg::PORT_B_DIRECTION_OFS:    state_d.pb_dir   = reg_wdata;
                ppol_pkg::PORT_C_OUTPUT_LATCH_OFS: state_d.pc_latch = reg_wdata;  // see RULE10
                ppol_pkg::PORT_C_DIRECTION_OFS:    state_d.pc_dir   = reg_wdata;  // see RULE10
                ppol_pkg::PORT_D_OUTPUT_LATCH_OFS: state_d.pd_latch = reg_wdata;  // see RULE16
                ppol_pkg::PORT_D_DIRECTION_OFS:    state_d.pd_dir   = reg_wdata;  // see RULE16
                default: begin
                    // Pin addresses are read-only (see RULE11)
                end
            endcase
        end
    end

    // State register, synchronous reset
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_q.pb_latch <= ppol_pkg::LATCH_RESET;
            state_q.pb_dir   <= ppol_pkg::DIRECTION_RESET;
            state_q.pc_latch <= ppol_pkg::LATCH_RESET;
            state_q.pc_dir   <= ppol_pkg::DIRECTION_RESET;
            state_q.pd_latch <= ppol_pkg::LATCH_RESET;
            state_q.pd_dir   <= ppol_pkg::DIRECTION_RESET;
            state_q.rd_data  <= ppol_pkg::READ_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // Read data straight from its flop
    assign reg_rdata = state_q.rd_data;
endmodule
`default_nettype wire

// file: verilog/ppol_pkg.sv
// Package of offsets, bit positions and reset values
package ppol_pkg;
    // Bus widths
    localparam int unsigned ADDR_W = 6;
    localparam int unsigned DATA_W = 8;
    // Register offsets in the I/O space
    localparam logic [5:0] PORT_D_PIN_LEVELS_OFS    = 6'h10;
    localparam logic [5:0] PORT_D_DIRECTION_OFS     = 6'h11;
    localparam logic [5:0] PORT_D_OUTPUT_LATCH_OFS  = 6'h12;
    localparam logic [5:0] PORT_C_PIN_LEVELS_OFS    = 6'h13;
    localparam logic [5:0] PORT_C_DIRECTION_OFS     = 6'h14;
    localparam logic [5:0] PORT_C_OUTPUT_LATCH_OFS  = 6'h15;
    localparam logic [5:0] PORT_B_PIN_LEVELS_OFS    = 6'h16;
    localparam logic [5:0] PORT_B_DIRECTION_OFS     = 6'h17;
    localparam logic [5:0] PORT_B_OUTPUT_LATCH_OFS  = 6'h18;
    // Reset values of the writable registers
    localparam logic [7:0] LATCH_RESET              = 8'h00;
    localparam logic [7:0] DIRECTION_RESET          = 8'h00;
    // Answer to an unmapped or idle read
    localparam logic [7:0] READ_IDLE                = 8'h00;
    // Port B alternate function bit positions
    localparam int unsigned PB_CNT0_BIT             = 0;
    localparam int unsigned PB_CNT1_BIT             = 1;
    localparam int unsigned PB_AIN_POS_BIT          = 2;
    localparam int unsigned PB_AIN_NEG_BIT          = 3;
    localparam int unsigned PB_SS_BIT               = 4;
    localparam int unsigned PB_MOSI_BIT             = 5;
    localparam int unsigned PB_MISO_BIT             = 6;
    localparam int unsigned PB_SCK_BIT              = 7;
    // Port C oscillator pin positions
    localparam int unsigned PC_OSC1_BIT             = 6;
    localparam int unsigned PC_OSC2_BIT             = 7;
    // Port D alternate function bit positions
    localparam int unsigned PD_RXD_BIT              = 0;
    localparam int unsigned PD_TXD_BIT              = 1;
    localparam int unsigned PD_IRQ0_BIT             = 2;
    localparam int unsigned PD_IRQ1_BIT             = 3;
    localparam int unsigned PD_CMP1B_BIT            = 4;
    localparam int unsigned PD_CMP1A_BIT            = 5;
    localparam int unsigned PD_CAPT_BIT             = 6;
    localparam int unsigned PD_CMP2_BIT             = 7;
    // Software visible state of the block
    typedef struct packed {
        logic [7:0] pb_latch;
        logic [7:0] pb_dir;
        logic [7:0] pc_latch;
        logic [7:0] pc_dir;
        logic [7:0] pd_latch;
        logic [7:0] pd_dir;
        logic [7:0] rd_data;
    } ppol_state_t;
endpackage

// file: verilog/ppol_sync.sv
// Two-stage synchronizer for a vector of pin levels
`timescale 1ns/1ps
`default_nettype none
module ppol_sync #(
    parameter int unsigned WIDTH = 24
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    // Both stages held in one state word
    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
    } ppol_sync_state_t;

    ppol_sync_state_t state_q;  // Registered stages
    ppol_sync_state_t state_d;  // Next stages

    // Shift the pins through two flops; only stage2 is read outside
    always_comb begin
        state_d        = state_q;
        state_d.stage1 = async_in;
        state_d.stage2 = state_q.stage1;
    end

    // Register stages
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign sync_out = state_q.stage2;
endmodule
`default_nettype wire

// file: verilog/ppol_pad.sv
// Per-pin pad control: drive, output enable and pull-up for one port
`timescale 1ns/1ps
`default_nettype none
module ppol_pad #(
    parameter int unsigned WIDTH = 8
) (
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] dir_eff,
    input  wire logic [WIDTH-1:0] out_val,
    input  wire logic [WIDTH-1:0] latch,
    input  wire logic [WIDTH-1:0] detach,
    output logic      [WIDTH-1:0] pin_out,
    output logic      [WIDTH-1:0] pin_oe_n,
    output logic      [WIDTH-1:0] pin_pullup
);
    // One pad cell per pin
    for (genvar i = 0; i < WIDTH; i++) begin : g_pad
        // Drive only when output, attached and reset released (see RULE12) (see RULE14)
        assign pin_oe_n[i]   = ~(dir_eff[i] & ~detach[i] & rst_n);
        // Pin value follows the selected source
        assign pin_out[i]    = out_val[i] & rst_n;
        // Pull-up needs input direction and latch one (see RULE13) (see RULE6)
        assign pin_pullup[i] = ~dir_eff[i] & latch[i] & ~detach[i] & rst_n;
    end
endmodule
`default_nettype wire

// file: verif/ppol_top_sva.sv
// Checker of pad, override and readback relations
`timescale 1ns/1ps
`default_nettype none
module ppol_top_sva (
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic       reg_re,
    input wire logic [7:0] reg_rdata,
    input wire logic [7:0] pb_in,
    input wire logic [7:0] pb_oe_n,
    input wire logic [7:0] pc_oe_n,
    input wire logic [7:0] pd_oe_n,
    input wire logic [7:0] pc_pullup_en,
    input wire logic       spi_enable,
    input wire logic       spi_master,
    input wire logic       spi_slave_active,
    input wire logic       power_down,
    input wire logic       async_timer2_clock_sel,
    input wire logic       timer0_count_in,
    input wire logic       comparator_pos_in,
    input wire logic       comparator_neg_in,
    input wire logic       uart_tx_enable,
    input wire logic       uart_rx_enable
);
    // One clock domain, reset masks all but the pad check
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    reset_tristate_a: assert property (disable iff (1'b0) !rst_n |-> &{pb_oe_n, pc_oe_n, pd_oe_n})
        else $error("pads driven during reset");
    miso_forced_a: assert property (spi_enable && spi_master |-> pb_oe_n[6])
        else $error("miso not input");
    slave_inputs_a: assert property (spi_enable && !spi_master
        |-> pb_oe_n[7] && pb_oe_n[5] && pb_oe_n[4]) else $error("slave pads not input");
    slave_select_a: assert property ($past(rst_n) && $past(rst_n, 2) && spi_enable && !spi_master
        |-> spi_slave_active == !$past(pb_in[4], 2)) else $error("slave active wrong");
    count_sync_a: assert property ($past(rst_n) && $past(rst_n, 2)
        |-> timer0_count_in == $past(pb_in[0], 2)) else $error("count source not synced");
    comp_gated_a: assert property (power_down |-> !comparator_pos_in && !comparator_neg_in)
        else $error("comparator live in power down");
    pullup_input_a: assert property ((pc_pullup_en & ~pc_oe_n) == 8'h00)
        else $error("pull-up on a driving pad");
    osc_detach_a: assert property (async_timer2_clock_sel
        |-> pc_oe_n[7:6] == 2'b11 && pc_pullup_en[7:6] == 2'b00) else $error("osc pads attached");
    txd_output_a: assert property (uart_tx_enable |-> !pd_oe_n[1])
        else $error("txd not output");
    rxd_input_a: assert property (uart_rx_enable |-> pd_oe_n[0])
        else $error("rxd not input");
    rdata_one_cycle_a: assert property ($past(rst_n) && !$past(reg_re) |-> reg_rdata == 8'h00)
        else $error("stale read data");
endmodule
`default_nettype wire

// file: verif/ppol_board.sv
// Board model of one port's pads
`timescale 1ns/1ps
`default_nettype none
module ppol_board (
    input  wire logic       clk,
    input  wire logic [7:0] oe_n,
    input  wire logic [7:0] out,
    input  wire logic [7:0] pull_on,
    input  wire logic [7:0] ext_en,
    input  wire logic [7:0] ext_val,
    output logic      [7:0] pin
);
    logic [7:0] float_q = 8'h55;  // Undriven lines wander, never hold a stale level
    // Float pattern toggles
    always @(posedge clk) begin
        float_q <= ~float_q;
    end
    // Block drive, else board drive, else pull-up or float
    assign pin = (~oe_n & out) | (oe_n & ext_en & ext_val) | (oe_n & ~ext_en & (pull_on | float_q));
endmodule
`default_nettype wire

// file: verif/test_port_pin_override_logic.sv
// Self-checking bench for the port override block
`timescale 1ns/1ps
`default_nettype none
module test_port_pin_override_logic;
    logic       clk, rst_n, reg_we, reg_re;
    logic [5:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, pbv, pbe, pcv, pce, pdv, pde;
    logic [7:0] pb_in, pb_out, pb_oe_n, pb_pullup_en, pc_in, pc_out, pc_oe_n, pc_pullup_en;
    logic [7:0] pd_in, pd_out, pd_oe_n, pd_pullup_en;
    logic       spi_enable, spi_master, spi_sck_out, spi_mosi_out, spi_miso_out;
    logic       spi_sck_in, spi_mosi_in, spi_miso_in, spi_slave_active, power_down;
    logic       async_timer2_clock_sel, timer0_count_in, timer1_count_in, comparator_pos_in;
    logic       comparator_neg_in, uart_tx_enable, uart_rx_enable, uart_txd, uart_rxd;
    logic       ext_irq0_in, ext_irq1_in, t1_capture_in, t1_compare_a_out, t1_compare_a_en;
    logic       t1_compare_b_out, t1_compare_b_en, t2_compare_out, t2_compare_en;
    int         fail_count, compares, cyc;

    // Block and three boards
    ppol_top i_ppol_top (.*);
    ppol_board i_ppol_board_b (.clk(clk), .oe_n(pb_oe_n), .out(pb_out), .pull_on(pb_pullup_en),
        .ext_en(pbe), .ext_val(pbv), .pin(pb_in));
    ppol_board i_ppol_board_c (.clk(clk), .oe_n(pc_oe_n), .out(pc_out), .pull_on(pc_pullup_en),
        .ext_en(pce), .ext_val(pcv), .pin(pc_in));
    ppol_board i_ppol_board_d (.clk(clk), .oe_n(pd_oe_n), .out(pd_out), .pull_on(pd_pullup_en),
        .ext_en(pde), .ext_val(pdv), .pin(pd_in));

    // Clock of 10 ns
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            fail_count++;
            final_report();
        end
    end

    task automatic final_report;
        $display("fail_count=%0d compares=%0d", fail_count, compares);
        if (fail_count == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Compare one byte
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Register write
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_we <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_we <= 1'b0;
        #1;
    endtask

    // Register read, data checked next cycle
    task automatic rdc(input logic [5:0] a, input logic [7:0] exp);
        @(posedge clk);
        reg_re <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_re <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask

    // Wait out the synchronizer
    task automatic sync_wait;
        repeat (3) @(posedge clk);
        #1;
    endtask

    task automatic t_regs;
        logic [5:0] ofs [6] = '{6'h11, 6'h12, 6'h14, 6'h15, 6'h17, 6'h18};
        foreach (ofs[i]) rdc(ofs[i], 8'h00);
        wr(6'h15, 8'hA5);
        rdc(6'h15, 8'hA5);
        wr(6'h13, 8'hFF);
        rdc(6'h14, 8'h00);
        wr(6'h3F, 8'h55);
        rdc(6'h3F, 8'h00);
    endtask

    task automatic t_port_c_output_latch;
        wr(6'h14, 8'hCF);
        wr(6'h15, 8'hFC);
        chk(pc_oe_n, 8'h30);
        chk(pc_out & 8'hCF, 8'hCC);
        chk(pc_pullup_en, 8'h30);
        sync_wait();
        rdc(6'h13, 8'hFC);
        @(posedge clk);
        async_timer2_clock_sel <= 1'b1;
        sync_wait();
        chk(pc_oe_n, 8'hF0);
        rdc(6'h13, 8'h3C);
        @(posedge clk);
        async_timer2_clock_sel <= 1'b0;
    endtask

    task automatic t_spi;
        wr(6'h17, 8'hF0);
        wr(6'h18, 8'h70);
        @(posedge clk);
        {spi_enable, spi_master, spi_sck_out, spi_mosi_out, spi_miso_out} <= 5'h1F;
        #1;
        chk({4'h0, pb_oe_n[7:4]}, 8'h04);
        chk({4'h0, pb_pullup_en[7:4]}, 8'h04);
        chk({6'h00, pb_out[7], pb_out[5]}, 8'h03);
        @(posedge clk);
        spi_master <= 1'b0;
        pbe <= 8'h10;
        pbv <= 8'h00;
        sync_wait();
        chk({4'h0, pb_oe_n[7:4]}, 8'h0B);
        chk({4'h0, pb_pullup_en[7:4]}, 8'h03);
        chk({5'h00, spi_mosi_in, spi_miso_in, pb_out[6]}, 8'h07);
        chk({7'h00, spi_slave_active}, 8'h01);
        @(posedge clk);
        pbv <= 8'h10;
        sync_wait();
        chk({7'h00, spi_slave_active}, 8'h00);
        @(posedge clk);
        spi_enable <= 1'b0;
    endtask

    task automatic t_cnt;
        wr(6'h17, 8'h00);
        @(posedge clk);
        pbe <= 8'hFF;
        pbv <= 8'h0F;
        sync_wait();
        chk({4'h0, timer1_count_in, timer0_count_in, comparator_neg_in, comparator_pos_in}, 8'h0F);
        rdc(6'h16, 8'h0F);
        chk({5'h00, spi_sck_in, spi_mosi_in, spi_miso_in}, 8'h00);
        @(posedge clk);
        power_down <= 1'b1;
        sync_wait();
        chk({6'h00, comparator_neg_in, comparator_pos_in}, 8'h00);
        rdc(6'h16, 8'h03);
        @(posedge clk);
        power_down <= 1'b0;
    endtask

    task automatic t_uart;
        wr(6'h11, 8'hB0);
        wr(6'h12, 8'h01);
        @(posedge clk);
        {uart_tx_enable, uart_rx_enable, uart_txd} <= 3'h7;
        {t1_compare_a_out, t1_compare_a_en, t1_compare_b_out, t1_compare_b_en, t2_compare_out, t2_compare_en} <= 6'h3F;
        pde <= 8'h4C;
        pdv <= 8'h4C;
        sync_wait();
        chk(pd_oe_n, 8'h4D);
        chk(pd_pullup_en, 8'h01);
        chk(pd_out & 8'hB2, 8'hB2);
        chk({4'h0, t1_capture_in, ext_irq1_in, ext_irq0_in, uart_rxd}, 8'h0F);
        rdc(6'h10, 8'hFF);
    endtask

    task automatic t_reset;
        @(posedge clk);
        rst_n <= 1'b0;
        #1;
        chk(pb_oe_n & pc_oe_n & pd_oe_n, 8'hFF);
        chk(pb_pullup_en | pc_pullup_en | pd_pullup_en, 8'h00);
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        rdc(6'h14, 8'h00);
    endtask

    // Main sequence
    initial begin
        {rst_n, reg_we, reg_re, reg_addr, reg_wdata, pbv, pbe, pcv, pce, pdv, pde} = '0;
        {spi_enable, spi_master, spi_sck_out, spi_mosi_out, spi_miso_out, power_down} = '0;
        {async_timer2_clock_sel, uart_tx_enable, uart_rx_enable, uart_txd} = '0;
        {t1_compare_a_out, t1_compare_a_en, t1_compare_b_out, t1_compare_b_en, t2_compare_out, t2_compare_en} = '0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        t_regs();
        t_port_c_output_latch();
        t_spi();
        t_cnt();
        t_uart();
        t_reset();
        final_report();
    end
endmodule

bind ppol_top ppol_top_sva i_ppol_top_sva (.*);
`default_nettype wire
